// ===== hw/sfr_cfg.svh
// constants of the special function status and reset register bank
// assumes the includer sits behind an already decoded byte-wide register port
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

`define SFR_ADDR_SPECIAL  8'h10
`define SFR_ADDR_RSV_LO   8'h0a
`define SFR_ADDR_RSV_HI   8'h0f
`define SFR_CMD_RESET     8'h5a
`define SFR_RD_IDLE       8'h00
`define SFR_BIT_BUSY      5
`define SFR_BIT_VALID     4
`define SFR_BIT_DLL       0
`define SFR_STATUS_FIXED  8'h04
`define SFR_ROM_LOAD_CYCLES 64

`endif

// ===== hw/sfr_pkg.sv
// types shared by the status bank and its rom load sequencer
// assumes sfr_cfg.svh is on the include path
package sfr_pkg;

  // gray along load -> check -> done
  typedef enum logic [1:0] {
    SFR_LD_LOAD  = 2'b00,
    SFR_LD_CHECK = 2'b01,
    SFR_LD_DONE  = 2'b11
  } sfr_ld_state_t;

  typedef struct packed {
    sfr_ld_state_t state;
    logic [15:0]   cnt;
    logic          busy;
    logic          valid;
  } sfr_ld_st_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rd_valid;
    logic       soft_reset;
    logic       busy;
    logic       valid;
    logic       dll;
  } sfr_top_st_t;

endpackage : sfr_pkg

// ===== hw/sfr_load_if.sv
// handshake between the status bank and the rom load sequencer
// assumes both ends run on the same control clock
`timescale 1ns/100ps
interface sfr_load_if;
  logic start;
  logic busy;
  logic valid;

  modport ctrl (output start, input busy, input valid);
  modport ldr  (input start, output busy, output valid);
endinterface : sfr_load_if

// ===== hw/sfr_rom_loader.sv
// rom configuration load sequencer with checksum verdict
// assumes chk_ok is the checksum result, stable in the check cycle
`timescale 1ns/100ps
`include "sfr_cfg.svh"
module sfr_rom_loader #(
  parameter int unsigned LOAD_CYCLES = `SFR_ROM_LOAD_CYCLES
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic chk_ok,
  sfr_load_if.ldr   lif
);
  import sfr_pkg::*;

  // counter is 16 bits wide
  if (LOAD_CYCLES < 1 || LOAD_CYCLES > 65536)
  begin : g_bad_cycles
    $error("sfr_rom_loader: LOAD_CYCLES out of range");
  end

  sfr_ld_st_t st_r;
  sfr_ld_st_t st_nxt;

  // load sequence; a start restarts it from any state
  always_comb
  begin
    st_nxt = st_r;
    case (st_r.state)
      SFR_LD_LOAD:
      begin
        if (st_r.cnt == 16'(LOAD_CYCLES - 1))
          st_nxt.state = SFR_LD_CHECK;
        else
          st_nxt.cnt = st_r.cnt + 16'h0001;
      end
      SFR_LD_CHECK:
      begin
        st_nxt.busy  = 1'b0;
        st_nxt.valid = chk_ok;
        st_nxt.state = SFR_LD_DONE;
      end
      SFR_LD_DONE:
        st_nxt = st_r;
      default:
        st_nxt.state = SFR_LD_DONE;
    endcase
    if (lif.start)
    begin
      st_nxt.state = SFR_LD_LOAD;
      st_nxt.cnt   = 16'h0000;
      st_nxt.busy  = 1'b1;
      st_nxt.valid = 1'b0;
    end
  end

  // power-up behaves as a load request
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      st_r <= '{state: SFR_LD_LOAD, cnt: 16'h0000, busy: 1'b1, valid: 1'b0};
    else
      st_r <= st_nxt;
  end

  assign lif.busy  = st_r.busy;
  assign lif.valid = st_r.valid;

  sequence s_check_pass;
    st_r.state == SFR_LD_CHECK && chk_ok;
  endsequence

  a_start_reload: assert property (@(posedge mclk) disable iff (!resetn)
    lif.start |=> st_r.busy && !st_r.valid && st_r.state == SFR_LD_LOAD && st_r.cnt == 16'h0000)
    else $error("reload did not restart");
  a_valid_cause: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(st_r.valid) |-> $past(st_r.state == SFR_LD_CHECK && chk_ok && !lif.start))
    else $error("valid set without passed checksum");
  a_check_pass: assert property (@(posedge mclk) disable iff (!resetn)
    s_check_pass ##0 !lif.start |=> st_r.valid && !st_r.busy)
    else $error("passed checksum not reported");
  a_load_ends: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(st_r.busy) ##1 (!lif.start) [*8] |-> ##[0:1000] !st_r.busy || lif.start)
    else $error("rom load never finished");

endmodule : sfr_rom_loader

// ===== hw/sfr_status_bank.sv
// special function register at 10h and reserved range 0Ah..0Fh
// assumes a decoded byte register port; other addresses belong to other banks
`timescale 1ns/100ps
`include "sfr_cfg.svh"
module sfr_status_bank #(
  parameter int unsigned LOAD_CYCLES = `SFR_ROM_LOAD_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  input  wire logic       rom_chk_ok,
  input  wire logic       dll_lock_in,
  output logic            soft_reset,
  output logic            rom_busy,
  output logic            regs_valid,
  output logic            dll_locked
);
  import sfr_pkg::*;

  sfr_top_st_t st_r;
  sfr_top_st_t st_nxt;
  sfr_load_if  lif ();
  logic        hit_sfr;
  logic        hit_rsv;
  logic [7:0]  status;

  sfr_rom_loader #(
    .LOAD_CYCLES (LOAD_CYCLES)
  ) u_loader (
    .mclk   (mclk),
    .resetn (resetn),
    .chk_ok (rom_chk_ok),
    .lif    (lif.ldr)
  );

  // address decode; reserved range is decoded only to be sure it stays inert
  assign hit_sfr = (reg_addr == `SFR_ADDR_SPECIAL);
  assign hit_rsv = (reg_addr >= `SFR_ADDR_RSV_LO) && (reg_addr <= `SFR_ADDR_RSV_HI);

  // status byte built from registered flags so a read is glitch free
  always_comb
  begin
    status                = `SFR_STATUS_FIXED;
    status[`SFR_BIT_BUSY]  = st_r.busy;
    status[`SFR_BIT_VALID] = st_r.valid;
    status[`SFR_BIT_DLL]   = st_r.dll;
  end

  // register port and flag capture
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rd_valid = reg_rd;
    if (reg_rd)
      st_nxt.rdata = hit_sfr ? status : `SFR_RD_IDLE;
    // any value but the command is dropped: it must never reach the rom
    st_nxt.soft_reset = reg_wr && hit_sfr && (reg_wdata == `SFR_CMD_RESET);
    st_nxt.busy  = lif.busy;
    st_nxt.valid = lif.valid;
    st_nxt.dll   = dll_lock_in;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      st_r <= '{rdata: 8'h00, rd_valid: 1'b0, soft_reset: 1'b0, busy: 1'b1, valid: 1'b0, dll: 1'b0};
    else
      st_r <= st_nxt;
  end

  // soft reset pulse also kicks the rom reload
  assign lif.start    = st_r.soft_reset;
  assign reg_rdata    = st_r.rdata;
  assign reg_rd_valid = st_r.rd_valid;
  assign soft_reset   = st_r.soft_reset;
  assign rom_busy     = st_r.busy;
  assign regs_valid   = st_r.valid;
  assign dll_locked   = st_r.dll;

  sequence s_reset_cmd;
    reg_wr && hit_sfr && reg_wdata == `SFR_CMD_RESET;
  endsequence

  sequence s_sfr_read;
    reg_rd && hit_sfr;
  endsequence

  a_reset_cmd: assert property (@(posedge mclk) disable iff (!resetn)
    s_reset_cmd |=> soft_reset)
    else $error("reset command not taken");
  a_reset_cause: assert property (@(posedge mclk) disable iff (!resetn)
    soft_reset |-> $past(reg_wr && hit_sfr && reg_wdata == `SFR_CMD_RESET))
    else $error("soft reset without command");
  a_status_fixed: assert property (@(posedge mclk) disable iff (!resetn)
    s_sfr_read |=> reg_rd_valid && reg_rdata[7:6] == 2'b00 && !reg_rdata[3] && reg_rdata[2] && !reg_rdata[1])
    else $error("fixed status bits wrong");
  a_busy_bit: assert property (@(posedge mclk) disable iff (!resetn)
    s_sfr_read |=> reg_rdata[`SFR_BIT_BUSY] == $past(rom_busy))
    else $error("busy bit mismatch");
  a_valid_bit: assert property (@(posedge mclk) disable iff (!resetn)
    s_sfr_read |=> reg_rdata[`SFR_BIT_VALID] == $past(regs_valid))
    else $error("valid bit mismatch");
  a_dll_bit: assert property (@(posedge mclk) disable iff (!resetn)
    s_sfr_read |=> reg_rd_valid && reg_rdata[`SFR_BIT_DLL] == $past(dll_locked))
    else $error("dll lock not tracked");
  a_reserved_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr || reg_rd) && hit_rsv |=> !soft_reset && (!reg_rd_valid || reg_rdata == 8'h00))
    else $error("reserved access had an effect");
  a_reload_flags: assert property (@(posedge mclk) disable iff (!resetn)
    soft_reset |-> ##2 rom_busy && !regs_valid)
    else $error("reload flags not raised");

endmodule : sfr_status_bank

// ===== tb/sfr_host_model.sv
// host model for the byte register port of the status bank
// assumes callers are at a falling mclk edge; strobes last one cycle
`timescale 1ns/100ps
module sfr_host_model (
  input  wire logic       mclk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid
);
  // idle lines carry inverted values so stale data never matches
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'hff;
    reg_wdata = 8'hff;
  end

  // one write strobe; address and data lines are inverted afterwards
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // answer is due exactly one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge mclk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    ok       = reg_rd_valid;
    d        = reg_rdata;
  endtask : rd
endmodule : sfr_host_model

// ===== tb/sfr_status_bank_test.sv
// self-checking bench for the special function status and reset bank
// assumes a short rom load length so each reload takes a few cycles
`timescale 1ns/100ps
module sfr_status_bank_test;
  localparam int unsigned LC = 4;
  logic       mclk = 1'b0;
  logic       resetn;
  logic       chk_ok;
  logic       dll_in;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rd_valid;
  logic       soft_reset;
  logic       rom_busy;
  logic       regs_valid;
  logic       dll_locked;
  int         errors;
  int         cmp_count;
  int         k;
  int         j;

  // 25 MHz control clock
  always #20 mclk = ~mclk;

  sfr_host_model i_sfr_host_model (
    .mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid)
  );

  sfr_status_bank #(.LOAD_CYCLES(LC)) i_sfr_status_bank (
    .mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .rom_chk_ok(chk_ok), .dll_lock_in(dll_in),
    .soft_reset(soft_reset), .rom_busy(rom_busy), .regs_valid(regs_valid),
    .dll_locked(dll_locked)
  );

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // read plus the one-cycle answer strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_sfr_host_model.rd(a, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask : rdchk

  // bounded wait for the load to end; k counts falling edges
  task automatic wait_load(inout int n);
    while (rom_busy !== 1'b0)
    begin
      @(negedge mclk);
      n++;
      if (n > 200)
      begin
        errors++;
        report_and_stop();
      end
    end
  endtask : wait_load

  initial
  begin
    resetn    = 1'b0;
    chk_ok    = 1'b1;
    dll_in    = 1'b1;
    errors    = 0;
    cmp_count = 0;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    rdchk(8'h10, 8'h25);
    k = 0;
    wait_load(k);
    rdchk(8'h10, 8'h15);
    // command with failing then passing checksum
    for (j = 0; j < 2; j++)
    begin
      chk_ok = j[0];
      i_sfr_host_model.wr(8'h10, 8'h5a);
      check({7'h00, soft_reset}, 8'h01);
      @(negedge mclk);
      check({7'h00, soft_reset}, 8'h00);
      @(negedge mclk);
      check({6'h00, rom_busy, regs_valid}, 8'h02);
      k = 3;
      wait_load(k);
      check(k[7:0], 8'(LC + 4));
      check({7'h00, regs_valid}, {7'h00, chk_ok});
      rdchk(8'h10, {3'b000, chk_ok, 4'h5});
    end
    // status read in mid-load
    i_sfr_host_model.wr(8'h10, 8'h5a);
    repeat (3) @(negedge mclk);
    rdchk(8'h10, 8'h25);
    k = 0;
    wait_load(k);
    // a value other than the command is dropped
    i_sfr_host_model.wr(8'h10, 8'ha5);
    check({7'h00, soft_reset}, 8'h00);
    repeat (2) @(negedge mclk);
    check({7'h00, rom_busy}, 8'h00);
    for (j = 8'h0a; j <= 8'h0f; j++)
    begin
      i_sfr_host_model.wr(j[7:0], 8'h5a);
      check({7'h00, soft_reset}, 8'h00);
      rdchk(j[7:0], 8'h00);
      check({7'h00, rom_busy}, 8'h00);
    end
    dll_in = 1'b0;
    rdchk(8'h10, 8'h14);
    check({7'h00, dll_locked}, 8'h00);
    report_and_stop();
  end
endmodule : sfr_status_bank_test
